// >>> rtl/cycle_time_base.sv
// Machine-cycle time base: 1 us tick, cycle counter, sync tracking, message budgets.
// Assumes sync pulses arrive from another clock domain; monitor data leaves via a FIFO.
//
// Function
// - Buffer 5 MHz, controller 10 MHz references
// - Buffer time base zeroed by sync discrete
// - No sync seen: buffer time base stays quiescent
// - Carrier edge: receive mode one millisecond
// - Missed sync edge: timing flywheels
// - Sync lost: keep timing, periodic sustained receive
// - Sync lost: keep gathering, pause in sustained
// - Pick sync source per unit kind
// - Controller recycles alone at 53000 us
// - Data sets: no time base, respond always
// - Data tap: no time base, hears anything
// - Deliver exactly 384 monitor messages per cycle
// - Unimplemented channel: zero message, no-response
// - Commands: 225 total, 112 per computer
// - Central buffer: 4 antenna, 6 central commands
// - Silent buffer sets no-response flag
`timescale 1ns/10ps
module cycle_time_base #(
  parameter int unsigned RECYCLE_US  = cycle_time_base_pkg::RECYCLE_US,
  parameter int unsigned TICK_CYCLES = cycle_time_base_pkg::TICK_CYCLES,
  parameter int unsigned NUM_CHAN    = 32,
  parameter int unsigned CMD_ACCEPT_US = cycle_time_base_pkg::CMD_ACCEPT_US
) (
  input  wire logic                                   core_clk,
  input  wire logic                                   rstn,
  input  wire logic [1:0]                             unit_kind,
  input  wire logic                                   cycle_sync_pulse,
  input  wire logic                                   track_hold_pulse,
  input  wire logic                                   carrier_on,
  input  wire logic [NUM_CHAN-1:0]                    chan_present,
  input  wire logic                                   mon_in_valid,
  input  wire logic [cycle_time_base_pkg::MSG_W-1:0]  mon_in_data,
  input  wire logic                                   mon_in_answered,
  output logic                                        mon_in_ready,
  output logic                                        mon_req,
  output logic [4:0]                                  mon_chan,
  output logic                                        mon_out_valid,
  input  wire logic                                   mon_out_ready,
  output logic [cycle_time_base_pkg::MSG_W-1:0]       mon_out_data,
  output logic                                        mon_out_no_resp,
  input  wire logic                                   cmd_valid,
  input  wire logic                                   cmd_from_b,
  input  wire logic                                   cmd_is_central,
  output logic                                        cmd_accept,
  output logic                                        cycle_start,
  output logic                                        us_tick,
  output logic [cycle_time_base_pkg::US_W-1:0]        cycle_us,
  output logic                                        time_running,
  output logic                                        receive_mode,
  output logic                                        sustained_receive,
  output logic                                        gather_enable,
  output logic [1:0]                                  sync_state
);
  localparam int unsigned UW = cycle_time_base_pkg::US_W;
  localparam int unsigned MW = cycle_time_base_pkg::MSG_W;
  localparam logic [1:0]  KIND_SLC = 2'h0;
  localparam logic [1:0]  KIND_ANT = 2'h1;
  localparam logic [1:0]  KIND_CEN = 2'h2;

  typedef struct packed {
    logic [1:0]                      sync_ff1;
    logic [1:0]                      sync_ff2;
    logic                            sync_last;
    logic [1:0]                      car_ff;
    logic                            car_last;
    logic [7:0]                      div;
    logic [UW-1:0]                   us;
    logic                            running;
    logic                            synced_this_cycle;
    logic [3:0]                      miss_cnt;
    logic [3:0]                      search_cnt;
    logic [UW-1:0]                   rx_left;
    logic [UW-1:0]                   hold_left;
    cycle_time_base_pkg::sync_state_e state;
    logic [8:0]                      mon_cnt;
    logic [4:0]                      chan;
    logic                            polling;
    logic [7:0]                      cmd_total;
    logic [6:0]                      cmd_a;
    logic [6:0]                      cmd_b;
    logic [2:0]                      ant_cnt;
    logic [2:0]                      cen_cnt;
  } tb_s;

  tb_s  st_reg;
  tb_s  st_next;
  logic sync_edge;
  logic car_edge;
  logic tick;
  logic cycle_end;
  logic push_valid;
  logic push_ready;
  logic [MW:0] push_data;
  logic [MW:0] pop_data;

  // The FIFO link travels as one bundle on each side, so both ends agree on its parts.
  msg_stream_if #(.WIDTH(MW)) push_if ();
  msg_stream_if #(.WIDTH(MW)) pop_if ();

  function automatic logic at_us(input logic [UW-1:0] now, input int unsigned t);
    return now == UW'(t);
  endfunction

  // The edge detector and its history bit must always look at the same source.
  function automatic logic pick_sync(input logic [1:0] ff, input logic [1:0] kind);
    return (kind == KIND_CEN) ? ff[1] : ff[0];
  endfunction

  function automatic logic polls_left(input logic [8:0] cnt);
    return cnt != 9'(cycle_time_base_pkg::MON_PER_CYCLE);
  endfunction

  // Pick the sync source for this unit kind; the first stage feeds only the second.
  assign sync_edge = pick_sync(st_reg.sync_ff2, unit_kind) && !st_reg.sync_last;
  assign car_edge  = st_reg.car_ff[1] && !st_reg.car_last;
  assign tick      = (st_reg.div == 8'(TICK_CYCLES - 1));
  assign cycle_end = tick && (st_reg.us == UW'(RECYCLE_US - 1));

  always_comb begin
    st_next            = st_reg;
    push_valid         = 1'b0;
    push_data          = '0;
    cmd_accept         = 1'b0;
    st_next.sync_ff1   = {track_hold_pulse, cycle_sync_pulse};
    st_next.sync_ff2   = st_reg.sync_ff1;
    st_next.sync_last  = pick_sync(st_reg.sync_ff2, unit_kind);
    st_next.car_ff     = {st_reg.car_ff[0], carrier_on};
    st_next.car_last   = st_reg.car_ff[1];
    st_next.div        = tick ? 8'h00 : st_reg.div + 8'h01;

    if (sync_edge) begin
      // A sync edge zeroes the cycle; the offset jitter between sources is absorbed
      // because each unit only ever looks at its own source.
      st_next.running           = 1'b1;
      st_next.us                = '0;
      st_next.div               = 8'h00;
      st_next.synced_this_cycle = 1'b1;
      st_next.miss_cnt          = '0;
      st_next.state             = cycle_time_base_pkg::SYNC_LOCKED;
    end else if (st_reg.running && tick) begin
      if (cycle_end) begin
        st_next.us = '0;
        st_next.synced_this_cycle = 1'b0;
        if (!st_reg.synced_this_cycle && st_reg.miss_cnt != 4'hf) begin
          st_next.miss_cnt = st_reg.miss_cnt + 4'h1;
        end
        if (!st_reg.synced_this_cycle) begin
          st_next.state = (st_reg.miss_cnt >= 4'(cycle_time_base_pkg::LOST_CYCLES - 1)) ?
                          cycle_time_base_pkg::SYNC_LOST : cycle_time_base_pkg::SYNC_FLYWHEEL;
        end
      end else begin
        st_next.us = st_reg.us + UW'(1);
      end
    end

    // The recycle point, or a sync edge that lands on a tick, resets the per-cycle budgets.
    if (st_reg.running && tick && (cycle_end || sync_edge)) begin
      st_next.mon_cnt   = '0;
      st_next.chan      = '0;
      st_next.polling   = 1'b0;
      st_next.cmd_total = '0;
      st_next.cmd_a     = '0;
      st_next.cmd_b     = '0;
      st_next.ant_cnt   = '0;
      st_next.cen_cnt   = '0;
    end

    // Antenna receive window on the carrier edge.
    if (car_edge && unit_kind == KIND_ANT) begin
      st_next.rx_left = UW'(cycle_time_base_pkg::RECEIVE_WINDOW_US);
    end else if (tick && st_reg.rx_left != '0) begin
      st_next.rx_left = st_reg.rx_left - UW'(1);
    end

    // Periodic sustained-receive search while lost; timing keeps running.
    if (st_reg.state == cycle_time_base_pkg::SYNC_LOST && unit_kind == KIND_ANT
        && tick && cycle_end) begin
      if (st_reg.search_cnt == 4'(cycle_time_base_pkg::SEARCH_PERIOD_CYC - 1)) begin
        st_next.search_cnt = '0;
        st_next.hold_left  = UW'(cycle_time_base_pkg::SEARCH_HOLD_US);
      end else begin
        st_next.search_cnt = st_reg.search_cnt + 4'h1;
      end
    end else if (tick && st_reg.hold_left != '0) begin
      st_next.hold_left = st_reg.hold_left - UW'(1);
    end

    // Monitor polling: one slot per channel in turn, wrapping after 32, exactly 384 per cycle.
    if (unit_kind == KIND_SLC && st_reg.running && tick
        && at_us(st_reg.us, cycle_time_base_pkg::MON_POLL_START_US)) begin
      st_next.polling = 1'b1;
    end
    if (st_reg.polling && polls_left(st_reg.mon_cnt)) begin
      if (!chan_present[st_reg.chan]) begin
        push_valid = 1'b1;
        push_data  = {1'b1, {MW{1'b0}}};
      end else if (mon_in_valid) begin
        push_valid = 1'b1;
        push_data  = {!mon_in_answered, mon_in_answered ? mon_in_data : {MW{1'b0}}};
      end
      if (push_valid && push_ready) begin
        st_next.mon_cnt = st_reg.mon_cnt + 9'h001;
        st_next.chan    = st_reg.chan + 5'h01;
      end
    end

    // Command budgets.
    if (cmd_valid && st_reg.running) begin
      if (unit_kind == KIND_SLC && st_reg.us >= UW'(CMD_ACCEPT_US)
          && st_reg.cmd_total != 8'(cycle_time_base_pkg::CMD_TOTAL_MAX)) begin
        if (!cmd_from_b && st_reg.cmd_a != 7'(cycle_time_base_pkg::CMD_PER_COMP_MAX)) begin
          cmd_accept = 1'b1;
          st_next.cmd_a = st_reg.cmd_a + 7'h01;
        end else if (cmd_from_b
                     && st_reg.cmd_b != 7'(cycle_time_base_pkg::CMD_PER_COMP_MAX)) begin
          cmd_accept = 1'b1;
          st_next.cmd_b = st_reg.cmd_b + 7'h01;
        end
        if (cmd_accept) begin
          st_next.cmd_total = st_reg.cmd_total + 8'h01;
        end
      end else if (unit_kind == KIND_CEN) begin
        if (cmd_is_central && st_reg.cen_cnt != 3'(cycle_time_base_pkg::CEN_CMD_MAX)) begin
          cmd_accept = 1'b1;
          st_next.cen_cnt = st_reg.cen_cnt + 3'h1;
        end else if (!cmd_is_central
                     && st_reg.ant_cnt != 3'(cycle_time_base_pkg::ANT_CMD_MAX)) begin
          cmd_accept = 1'b1;
          st_next.ant_cnt = st_reg.ant_cnt + 3'h1;
        end
      end
    end

    // Without a sync the controller still counts; the buffers stay idle.
    if (!st_reg.running && unit_kind == KIND_SLC) begin
      st_next.running = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Buffer outputs other than receive_mode hold low until the first sync edge starts the time base.
  assign time_running      = st_reg.running;
  assign us_tick           = tick && st_reg.running;
  assign cycle_us          = st_reg.us;
  assign cycle_start       = st_reg.running && (sync_edge || cycle_end);
  assign receive_mode      = (st_reg.rx_left != '0) || (st_reg.hold_left != '0);
  assign sustained_receive = (st_reg.hold_left != '0);
  assign gather_enable     = st_reg.running && (st_reg.hold_left == '0);
  assign sync_state        = st_reg.state;
  assign mon_chan          = st_reg.chan;
  assign mon_req           = st_reg.polling && chan_present[st_reg.chan]
                             && polls_left(st_reg.mon_cnt);
  assign mon_in_ready      = mon_req && push_ready;

  assign push_if.valid     = push_valid;
  assign push_if.data      = push_data[MW-1:0];
  assign push_if.no_resp   = push_data[MW];
  assign push_ready        = push_if.ready;
  assign pop_if.ready      = mon_out_ready;
  assign pop_if.data       = pop_data[MW-1:0];
  assign pop_if.no_resp    = pop_data[MW];
  assign mon_out_valid     = pop_if.valid;
  assign mon_out_no_resp   = pop_if.no_resp;
  assign mon_out_data      = pop_if.data;

  msg_fifo #(
    .WIDTH (MW + 1),
    .DEPTH (cycle_time_base_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (push_if.valid),
    .in_ready  (push_if.ready),
    .in_data   ({push_if.no_resp, push_if.data}),
    .out_valid (pop_if.valid),
    .out_ready (pop_if.ready),
    .out_data  (pop_data)
  );
endmodule

// >>> rtl/cycle_time_base_pkg.sv
// Package for the machine-cycle time base: timing constants, capacities and modes.
// Assumes core_clk at 125 MHz; all slower rates come from one-cycle enables.
package cycle_time_base_pkg;

  localparam int unsigned CLK_MHZ           = 125;
  localparam int unsigned TICK_US           = 1;
  localparam int unsigned TICK_CYCLES       = CLK_MHZ * TICK_US;
  localparam int unsigned RECYCLE_US        = 53000;
  localparam int unsigned RECEIVE_WINDOW_US = 1000;
  localparam int unsigned MON_POLL_START_US = 1024;
  localparam int unsigned CMD_ACCEPT_US     = 29000;
  localparam int unsigned SEARCH_PERIOD_CYC = 8;
  localparam int unsigned SEARCH_HOLD_US    = 2000;
  localparam int unsigned LOST_CYCLES       = 4;
  localparam int unsigned MON_PER_CYCLE     = 384;
  localparam int unsigned CMD_TOTAL_MAX     = 225;
  localparam int unsigned CMD_PER_COMP_MAX  = 112;
  localparam int unsigned ANT_CMD_MAX       = 4;
  localparam int unsigned CEN_CMD_MAX       = 6;
  localparam int unsigned MSG_W             = 48;
  localparam int unsigned FIFO_DEPTH        = 8;
  localparam int unsigned US_W              = 16;

  typedef enum logic [1:0] {
    SYNC_IDLE,
    SYNC_LOCKED,
    SYNC_FLYWHEEL,
    SYNC_LOST
  } sync_state_e;

endpackage

// >>> rtl/msg_fifo.sv
// Flop-based message FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module msg_fifo #(
  parameter int unsigned WIDTH = 49,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_s;

  fifo_s st_reg;
  fifo_s st_next;
  logic  push;
  logic  pop;

  assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = st_reg.mem[st_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + AW'(1);
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + AW'(1);
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// >>> rtl/msg_stream_if.sv
// Interface carrying monitor messages between the time base and its FIFO.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface msg_stream_if #(
  parameter int unsigned WIDTH = 48
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  logic             no_resp;

  modport src (output valid, output data, output no_resp, input ready);
  modport dst (input valid, input data, input no_resp, output ready);
endinterface

// >>> verif/cycle_time_base_props.sv
// Checker for the cycle time base: tick spacing, cycle bound, unit gating and filler messages.
// Assumes it is bound to cycle_time_base and that the bench runs with TICK_CYCLES of 4 to 8.
`timescale 1ns/10ps
module cycle_time_base_props #(
  parameter int unsigned RECYCLE_US  = 53000,
  parameter int unsigned TICK_CYCLES = 125,
  parameter int unsigned NUM_CHAN    = 32
) (
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire logic [1:0]          unit_kind,
  input wire logic [NUM_CHAN-1:0] chan_present,
  input wire logic                cmd_valid,
  input wire logic                cmd_accept,
  input wire logic                mon_req,
  input wire logic [4:0]          mon_chan,
  input wire logic                mon_out_valid,
  input wire logic [47:0]         mon_out_data,
  input wire logic                mon_out_no_resp,
  input wire logic                cycle_start,
  input wire logic                us_tick,
  input wire logic [15:0]         cycle_us,
  input wire logic                time_running,
  input wire logic                receive_mode,
  input wire logic                sustained_receive,
  input wire logic                gather_enable,
  input wire logic [1:0]          sync_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_tick_spacing: assert property (us_tick |=> !us_tick [*3])
    else $error("microsecond ticks too close");
  a_tick_after_run: assert property ($rose(time_running) |-> ##[1:8] us_tick)
    else $error("no tick after time base started");
  a_cycle_bound: assert property (cycle_us < RECYCLE_US)
    else $error("cycle count passed the recycle point");
  a_start_zeroes: assert property (cycle_start |=> cycle_us == '0)
    else $error("cycle start did not zero the count");
  a_accept_cause: assert property (cmd_accept |-> cmd_valid)
    else $error("command accepted without an offer");
  a_idle_quiet: assert property (unit_kind != 2'd0 && sync_state == 2'd0 |-> !us_tick && !mon_req)
    else $error("idle buffer produced timing");
  a_receive_unit: assert property (receive_mode || sustained_receive |-> unit_kind == 2'd1)
    else $error("receive mode outside antenna timing");
  a_pause_gather: assert property (sustained_receive |-> !gather_enable)
    else $error("gathering during sustained receive");
  a_poll_present: assert property (mon_req |-> chan_present[mon_chan])
    else $error("absent channel polled");
  a_filler_zero: assert property (mon_out_valid && mon_out_no_resp |-> mon_out_data == '0)
    else $error("filler message not all zero");
endmodule

bind cycle_time_base cycle_time_base_props #(
  .RECYCLE_US(RECYCLE_US), .TICK_CYCLES(TICK_CYCLES), .NUM_CHAN(NUM_CHAN)
) props (.core_clk, .rstn, .unit_kind, .chan_present, .cmd_valid, .cmd_accept, .mon_req,
  .mon_chan, .mon_out_valid, .mon_out_data, .mon_out_no_resp, .cycle_start, .us_tick,
  .cycle_us, .time_running, .receive_mode, .sustained_receive, .gather_enable, .sync_state);

// >>> verif/cycle_time_base_tb.sv
// Self-checking bench for the cycle time base with shortened microsecond and cycle counts.
// Assumes the bound checker and the partner model; one clock, synchronous reset.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
`define STEP(n) repeat (n) begin @(posedge core_clk); #1; end
`define WAIT(c, lim) begin for (int w = 0; w < (lim) && !(c); w++) `STEP(1) if (!(c)) begin mismatches++; end_sim(); end end
module cycle_time_base_tb;
  localparam int RECYCLE = 1300;
  localparam int CYC     = RECYCLE * 4;
  logic        core_clk = 0, rstn = 0, cycle_sync_pulse = 0, track_hold_pulse = 0;
  logic        carrier_on = 0, cmd_valid = 0, cmd_from_b = 0, cmd_is_central = 0, stall = 0;
  logic [1:0]  unit_kind = 2'd0, sync_state;
  logic [31:0] chan_present = 32'hfff0_ffff, mute_mask = 32'h0000_0020;
  logic        mon_in_valid, mon_in_answered, mon_in_ready, mon_req, mon_out_valid;
  logic        mon_out_ready, mon_out_no_resp, cmd_accept, cycle_start, us_tick;
  logic        time_running, receive_mode, sustained_receive, gather_enable;
  logic [4:0]  mon_chan, c;
  logic [47:0] mon_in_data, mon_out_data;
  logic [15:0] cycle_us;
  int          mismatches = 0, n_checks = 0, pops = 0, acc;
  time         t0;
  always #4 core_clk = ~core_clk;
  cycle_time_base #(.RECYCLE_US(RECYCLE), .TICK_CYCLES(4), .NUM_CHAN(32), .CMD_ACCEPT_US(1200))
    DUT (.core_clk,
    .rstn, .unit_kind, .cycle_sync_pulse, .track_hold_pulse, .carrier_on, .chan_present,
    .mon_in_valid, .mon_in_data, .mon_in_answered, .mon_in_ready, .mon_req, .mon_chan,
    .mon_out_valid, .mon_out_ready, .mon_out_data, .mon_out_no_resp, .cmd_valid, .cmd_from_b,
    .cmd_is_central, .cmd_accept, .cycle_start, .us_tick, .cycle_us, .time_running,
    .receive_mode, .sustained_receive, .gather_enable, .sync_state);
  mon_partner partner (.core_clk, .mute_mask, .stall, .mon_req, .mon_chan, .mon_in_ready,
    .mon_in_valid, .mon_in_data, .mon_in_answered, .mon_out_ready);
  // Entries leave in channel order, so the channel is known from the count in the cycle.
  always @(posedge core_clk) begin
    c = pops[4:0];
    if (cycle_start) pops = 0;
    else if (mon_out_valid && mon_out_ready) begin
      `CHK(mon_out_no_resp, !chan_present[c] || mute_mask[c])
      `CHK(mon_out_data, (!chan_present[c] || mute_mask[c]) ? 48'h0 : {43'h05a5, c})
      pops++;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic reset_to(input logic [1:0] kind);
    `STEP(1)
    rstn = 0;
    unit_kind = kind;
    `STEP(5)
    rstn = 1;
  endtask
  task automatic offer(input logic central, input int n);
    acc = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      #1;
      cmd_valid = 1;
      cmd_is_central = central;
      cmd_from_b = i[0];
      #5 acc += (cmd_accept === 1'b1) ? 1 : ((cmd_accept === 1'b0) ? 0 : 1000);
    end
    `STEP(1)
    cmd_valid = 0;
  endtask
  task automatic t_controller;
    reset_to(2'd0);
    `CHK(sync_state, 2'd0)
    `WAIT(cycle_start, 2 * CYC)
    t0 = $time;
    stall = 1;
    `WAIT(mon_req && !mon_in_ready, CYC)
    `CHK(mon_out_valid, 1'b1)
    `STEP(30)
    stall = 0;
    offer(1'b0, 20);
    `CHK(acc, 0)
    `WAIT(cycle_us >= 16'h04b0, CYC)
    offer(1'b0, 240);
    `CHK(acc, 224)
    `WAIT(cycle_start, CYC)
    `CHK(int'(($time - t0) / 8), CYC)
    `CHK(pops, 384)
  endtask
  task automatic t_central;
    reset_to(2'd2);
    `STEP(50)
    cycle_sync_pulse = 1;
    `STEP(4)
    cycle_sync_pulse = 0;
    `STEP(36)
    `CHK(time_running, 1'b0)
    track_hold_pulse = 1;
    `STEP(4)
    track_hold_pulse = 0;
    `WAIT(time_running, 20)
    offer(1'b0, 8);
    `CHK(acc, 4)
    offer(1'b1, 8);
    `CHK(acc, 6)
  endtask
  task automatic t_antenna;
    reset_to(2'd1);
    cycle_sync_pulse = 1;
    `STEP(4)
    cycle_sync_pulse = 0;
    `WAIT(time_running, 20)
    carrier_on = 1;
    `STEP(4)
    carrier_on = 0;
    `WAIT(receive_mode, 10)
    `WAIT(sync_state == 2'd2, 2 * CYC)
    `CHK(time_running, 1'b1)
    `WAIT(sync_state == 2'd3, 5 * CYC)
    `WAIT(sustained_receive, 9 * CYC)
    `CHK(time_running, 1'b1)
    `CHK(gather_enable, 1'b0)
  endtask
  initial begin
    t_controller();
    t_central();
    t_antenna();
    end_sim();
  end
endmodule

// >>> verif/mon_partner.sv
// Model of the polled buffers and the computer side that drains the monitor stream.
// Assumes core_clk is shared; replies change 1 ns after the rising edge.
`timescale 1ns/10ps
module mon_partner (
  input wire logic        core_clk,
  input wire logic [31:0] mute_mask,
  input wire logic        stall,
  input wire logic        mon_req,
  input wire logic [4:0]  mon_chan,
  input wire logic        mon_in_ready,
  output logic            mon_in_valid,
  output logic [47:0]     mon_in_data,
  output logic            mon_in_answered,
  output logic            mon_out_ready
);
  logic taken;
  // A reply is held until taken; a released data bus toggles so stale values never match.
  initial begin
    mon_in_valid = 1'b0;
    mon_in_data = '0;
    mon_in_answered = 1'b0;
    mon_out_ready = 1'b0;
    forever begin
      @(posedge core_clk);
      taken = mon_in_valid && mon_in_ready;
      #1;
      mon_out_ready = !stall;
      if (taken || !mon_in_valid) begin
        mon_in_valid = mon_req;
        mon_in_answered = !mute_mask[mon_chan];
        mon_in_data = mon_req ? {43'h05a5, mon_chan} : ~mon_in_data;
      end
    end
  end
endmodule
